// >>> hdl/par_pkg.sv
package par_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 16;
   // printed register numbers are indices; byte address is four times the index
   localparam logic [7:0] IDX_VID_LO  = 8'h02;
   localparam logic [7:0] IDX_VID_HI  = 8'h03;
   localparam logic [7:0] IDX_ADVERT  = 8'h04;
   localparam logic [7:0] IDX_PARTNER = 8'h05;
   localparam logic [7:0] IDX_VCTRL   = 8'h10;
   localparam logic [7:0] IDX_PHYSTAT = 8'h20;

   // bit positions shared by advertisement and partner words
   localparam int unsigned B_NEXT_PAGE = 15;
   localparam int unsigned B_CONFIRMED = 14;
   localparam int unsigned B_REM_FAULT = 13;
   localparam int unsigned B_PAUSE_HI  = 12;
   localparam int unsigned B_PAUSE_LO  = 10;
   localparam int unsigned B_FOUR_PAIR = 9;
   localparam int unsigned B_FAST_FD   = 8;
   localparam int unsigned B_FAST_HD   = 7;
   localparam int unsigned B_TEN_FD    = 6;
   localparam int unsigned B_TEN_HD    = 5;
   localparam logic [4:0]  PROTO_FAMILY = 5'h01;
   localparam logic [3:0]  ABIL_RST     = 4'hf;
   localparam logic [2:0]  PAUSE_RST    = 3'h0;

   // vendor control field positions
   localparam int unsigned C_HUB     = 15;
   localparam int unsigned C_IRQPOL  = 14;
   localparam int unsigned C_SET_HI  = 13;
   localparam int unsigned C_SET_LO  = 12;
   localparam int unsigned C_HBT_OFF = 11;
   localparam int unsigned C_ARB_IDL = 10;
   localparam int unsigned C_RELOAD  = 9;
   localparam int unsigned C_EDSLEEP = 8;
   localparam int unsigned C_FEF     = 7;
   localparam int unsigned C_XFRATIO = 6;
   localparam int unsigned C_POLOFF  = 5;
   localparam int unsigned C_FORCELK = 4;
   localparam int unsigned C_JABBYP  = 2;
   localparam int unsigned C_WHITEN  = 1;
   localparam int unsigned C_FIBER   = 0;
   localparam logic [15:0] VCTRL_RST = 16'h0602;
   localparam logic [15:0] VCTRL_WMASK = 16'hfff7;

   // physical status bits of the index 0x20 word
   localparam int unsigned S_LINK   = 0;
   localparam int unsigned S_ARB_OK = 1;
   localparam int unsigned S_RELOAD = 2;
   localparam int unsigned S_SLEEP  = 3;
   localparam int unsigned S_IRQ    = 4;

   // settle times in microseconds and their cycle counts at 100 MHz
   localparam int unsigned CLK_MHZ   = 100;
   localparam int unsigned SET0_US   = 700;
   localparam int unsigned SET1_US   = 1000;
   localparam int unsigned SET2_US   = 5000;
   localparam int unsigned SET3_US   = 45000;
   localparam int unsigned SET0_CYC  = SET0_US * CLK_MHZ;
   localparam int unsigned SET1_CYC  = SET1_US * CLK_MHZ;
   localparam int unsigned SET2_CYC  = SET2_US * CLK_MHZ;
   localparam int unsigned SET3_CYC  = SET3_US * CLK_MHZ;
   localparam int unsigned SET_CNT_W = 23;

   typedef enum logic [1:0] {SETTLE_700US, SETTLE_1MS, SETTLE_5MS, SETTLE_45MS} par_settle_type;

   typedef struct packed {
      logic link_pulse_ok;
      logic burst_rx_idle;
      logic link_x_ready;
      logic link_by_nlp;
      logic descr_locked;
      logic st_quiet;
      logic st_halt;
      logic st_master;
      logic st_idle;
      logic energy_seen;
      logic irq_event;
   } par_line_in_type;

   typedef struct packed {
      logic full_duplex_allow;
      logic heartbeat_on;
      logic crs_rx_only;
      logic irq_pin;
      logic link_up;
      logic arb_link_ready;
      logic descr_reload;
      logic power_save;
      logic far_end_fault_on;
      logic ratio_1p25;
      logic auto_polarity_on;
      logic jabber_on;
      logic whitening_on;
      logic fiber_on;
      logic [3:0] adv_abilities;
      logic [2:0] adv_pause;
   } par_line_out_type;
endpackage : par_pkg

// >>> hdl/par_regs.sv
`timescale 1ns/1ps
module par_regs
   import par_pkg::*;
#(
   parameter logic [15:0] VENDOR_ID_LOW  = 16'h1234, // arbitrary value
   parameter logic [5:0]  VENDOR_ID_HIGH = 6'h2a,    // arbitrary value
   parameter int unsigned SET0_CYCLES    = par_pkg::SET0_CYC,
   parameter int unsigned SET1_CYCLES    = par_pkg::SET1_CYC,
   parameter int unsigned SET2_CYCLES    = par_pkg::SET2_CYC,
   parameter int unsigned SET3_CYCLES    = par_pkg::SET3_CYC
) (
   // clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      clk_en,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [par_pkg::ADDR_W-1:0] paddr,
   input  wire logic [par_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [par_pkg::DATA_W-1:0] prdata,
   output logic                           pready,
   output logic                           pslverr,
   // line side: negotiation results from the same clock
   input  wire logic [15:0]               partner_word,
   input  wire logic                      partner_load,
   input  wire logic                      word_confirmed,
   input  wire logic                      remote_fault,
   // line side: status from the analog front end (asynchronous)
   input  wire par_pkg::par_line_in_type  line_in,
   output par_pkg::par_line_out_type      line_out
);
   import par_pkg::*;

   // a zero count waits the whole counter range, a wide one would wrap the counter
   if (SET0_CYCLES < 1 || SET1_CYCLES < 1 ||
       SET2_CYCLES < 1 || SET3_CYCLES < 1) begin : g_zero_cnt
      $error("settle counts must be at least one");
   end
   if (SET0_CYCLES >= (1 << SET_CNT_W) || SET1_CYCLES >= (1 << SET_CNT_W) ||
       SET2_CYCLES >= (1 << SET_CNT_W) || SET3_CYCLES >= (1 << SET_CNT_W)) begin : g_wide_cnt
      $error("settle count too wide for counter");
   end

   logic [15:0]           advert_r;
   logic [15:0]           partner_r;
   logic [15:0]           vctrl_r;
   logic [15:0]           vctrl_nxt;
   logic [15:0]           advert_nxt;
   par_line_in_type       s1_r;
   par_line_in_type       s2_r;
   par_line_in_type       s3_r;
   par_line_in_type       line_r;
   logic [SET_CNT_W-1:0]  settle_cnt_r;
   logic                  link_r;
   logic                  access;
   logic                  wr_hit;
   logic [7:0]            idx;
   logic                  idx_ok;
   logic [15:0]           rd_word;
   logic [15:0]           wmask;
   logic [SET_CNT_W-1:0]  settle_lim;
   logic                  settle_active;
   par_line_out_type      out_nxt;

   assign access = psel && penable;
   assign idx    = paddr[9:2];
   assign idx_ok = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0) &&
                   (idx == IDX_VID_LO || idx == IDX_VID_HI || idx == IDX_ADVERT ||
                    idx == IDX_PARTNER || idx == IDX_VCTRL || idx == IDX_PHYSTAT);
   assign wr_hit = access && pready && pwrite && idx_ok;
   assign wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // three-stage synchroniser; only stages two and three are compared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         line_r <= '0;
      end else if (clk_en) begin
         s1_r <= line_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < $bits(par_line_in_type); i++) begin
            if (s2_r[i] == s3_r[i])
               line_r[i] <= s3_r[i];
         end
      end
   end

   always_comb begin
      advert_nxt = advert_r;
      if (wr_hit && idx == IDX_ADVERT) begin
         // only pause storage and the four ability bits take writes
         advert_nxt[B_PAUSE_HI:B_PAUSE_LO] =
            (pwdata[B_PAUSE_HI:B_PAUSE_LO] & wmask[B_PAUSE_HI:B_PAUSE_LO]) |
            (advert_r[B_PAUSE_HI:B_PAUSE_LO] & ~wmask[B_PAUSE_HI:B_PAUSE_LO]);
         advert_nxt[B_FAST_FD:B_TEN_HD] =
            (pwdata[B_FAST_FD:B_TEN_HD] & wmask[B_FAST_FD:B_TEN_HD]) |
            (advert_r[B_FAST_FD:B_TEN_HD] & ~wmask[B_FAST_FD:B_TEN_HD]);
      end
      advert_nxt[B_FOUR_PAIR] = 1'b0;
      advert_nxt[B_NEXT_PAGE] = 1'b0;
      advert_nxt[4:0]         = PROTO_FAMILY;
      // same one-cycle lag as the partner word
      advert_nxt[B_CONFIRMED] = word_confirmed;
      advert_nxt[B_REM_FAULT] = remote_fault;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         advert_r <= {1'b0, 1'b0, 1'b0, PAUSE_RST, 1'b0, ABIL_RST, PROTO_FAMILY};
      end else if (clk_en) begin
         advert_r <= advert_nxt;
      end
   end

   // partner word: only the four-pair and ability bits load from partner_word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         partner_r <= {11'h000, PROTO_FAMILY};
      end else if (clk_en) begin
         if (partner_load)
            partner_r[B_FOUR_PAIR:B_TEN_HD] <= partner_word[B_FOUR_PAIR:B_TEN_HD];
         partner_r[B_NEXT_PAGE] <= 1'b0;
         partner_r[B_CONFIRMED] <= word_confirmed;
         partner_r[B_REM_FAULT] <= remote_fault;
         partner_r[B_PAUSE_HI:B_PAUSE_LO] <= 3'h0;
         partner_r[4:0] <= PROTO_FAMILY;
      end
   end

   always_comb begin
      vctrl_nxt = vctrl_r;
      if (wr_hit && idx == IDX_VCTRL)
         vctrl_nxt = ((pwdata[15:0] & wmask) | (vctrl_r & ~wmask)) & VCTRL_WMASK;
      // fiber mode wins over any scrambler write, including the same cycle
      if (vctrl_nxt[C_FIBER])
         vctrl_nxt[C_WHITEN] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vctrl_r <= VCTRL_RST;
      end else if (clk_en) begin
         vctrl_r <= vctrl_nxt;
      end
   end

   always_comb begin
      case (par_settle_type'(vctrl_r[C_SET_HI:C_SET_LO]))
         SETTLE_700US: settle_lim = SET_CNT_W'(SET0_CYCLES);
         SETTLE_1MS:   settle_lim = SET_CNT_W'(SET1_CYCLES);
         SETTLE_5MS:   settle_lim = SET_CNT_W'(SET2_CYCLES);
         SETTLE_45MS:  settle_lim = SET_CNT_W'(SET3_CYCLES);
         default:      settle_lim = SET_CNT_W'(SET0_CYCLES);
      endcase
   end

   // link is up after the pulses have been good for the settle time
   assign settle_active = line_r.link_pulse_ok && !link_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_cnt_r <= '0;
         link_r       <= 1'b0;
      end else if (clk_en) begin
         if (vctrl_r[C_FORCELK]) begin
            link_r       <= 1'b1;
            settle_cnt_r <= '0;
         end else if (!line_r.link_pulse_ok) begin
            link_r       <= 1'b0;
            settle_cnt_r <= '0;
         end else if (settle_active) begin
            if (settle_cnt_r >= settle_lim - SET_CNT_W'(1)) begin
               link_r       <= 1'b1;
               settle_cnt_r <= '0;
            end else begin
               settle_cnt_r <= settle_cnt_r + SET_CNT_W'(1);
            end
         end
      end
   end

   always_comb begin
      out_nxt                   = '0;
      out_nxt.full_duplex_allow = !vctrl_r[C_HUB];
      out_nxt.heartbeat_on      = !vctrl_r[C_HUB] && !vctrl_r[C_HBT_OFF];
      out_nxt.crs_rx_only       = vctrl_r[C_HUB];
      out_nxt.irq_pin           = vctrl_r[C_IRQPOL] ? line_r.irq_event
                                                    : !line_r.irq_event;
      out_nxt.link_up           = link_r;
      out_nxt.arb_link_ready    =
         (vctrl_r[C_ARB_IDL] ? line_r.burst_rx_idle : 1'b1) &&
         ((!line_r.link_by_nlp && line_r.link_x_ready) ||
          (line_r.link_by_nlp && !line_r.link_x_ready));
      out_nxt.descr_reload      = !line_r.descr_locked &&
         (vctrl_r[C_RELOAD] ? (line_r.st_quiet || line_r.st_halt ||
                               line_r.st_master || line_r.st_idle)
                            : line_r.st_idle);
      out_nxt.power_save        = vctrl_r[C_EDSLEEP] && !line_r.energy_seen;
      out_nxt.far_end_fault_on  = vctrl_r[C_FEF];
      out_nxt.ratio_1p25        = vctrl_r[C_XFRATIO];
      out_nxt.auto_polarity_on  = !vctrl_r[C_POLOFF];
      out_nxt.jabber_on         = !vctrl_r[C_JABBYP];
      out_nxt.whitening_on      = vctrl_r[C_WHITEN];
      out_nxt.fiber_on          = vctrl_r[C_FIBER];
      out_nxt.adv_abilities     = advert_r[B_FAST_FD:B_TEN_HD];
      out_nxt.adv_pause         = advert_r[B_PAUSE_HI:B_PAUSE_LO];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // matches the outputs implied by the control reset value
         line_out <= '{full_duplex_allow: 1'b1, heartbeat_on: 1'b1, crs_rx_only: 1'b0,
                       irq_pin: 1'b1, link_up: 1'b0, arb_link_ready: 1'b0,
                       descr_reload: 1'b0, power_save: 1'b0, far_end_fault_on: 1'b0,
                       ratio_1p25: 1'b0, auto_polarity_on: 1'b1, jabber_on: 1'b1,
                       whitening_on: 1'b1, fiber_on: 1'b0, adv_abilities: ABIL_RST,
                       adv_pause: PAUSE_RST};
      end else if (clk_en) begin
         line_out <= out_nxt;
      end
   end

   always_comb begin
      case (idx)
         IDX_VID_LO:  rd_word = VENDOR_ID_LOW;
         IDX_VID_HI:  rd_word = {VENDOR_ID_HIGH, 6'h00, 4'h0};
         IDX_ADVERT:  rd_word = advert_r;
         IDX_PARTNER: rd_word = partner_r;
         IDX_VCTRL:   rd_word = vctrl_r;
         IDX_PHYSTAT: rd_word = {11'h000, line_out.irq_pin, line_out.power_save,
                                 line_out.descr_reload, line_out.arb_link_ready, link_r};
         default:     rd_word = 16'h0000;
      endcase
   end

   // no wait state; keyed on pready so a setup missed while frozen is still answered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (clk_en) begin
         pready  <= psel && !pready;
         pslverr <= psel && !pready && !idx_ok;
         prdata  <= (psel && !pready && !pwrite && idx_ok) ? {16'h0000, rd_word} : '0;
      end
   end
endmodule : par_regs

// >>> testbench/par_mgmt_model.sv
`timescale 1ns/1ps
module par_mgmt_model
   import par_pkg::*;
(
   // clock
   input  wire logic                      pclk,
   // apb master
   output logic                           psel,
   output logic                           penable,
   output logic                           pwrite,
   output logic [par_pkg::ADDR_W-1:0]     paddr,
   output logic [par_pkg::DATA_W-1:0]     pwdata,
   output logic [3:0]                     pstrb,
   input  wire logic                      pready
);
   initial begin
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = 4'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic ok);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // released bus shows inverted values so stale data never looks valid
      psel <= 1'b0; penable <= 1'b0; paddr <= ~a; pwdata <= ~d;
      ok = (pready === 1'b1);
   endtask : xfer
endmodule : par_mgmt_model

// >>> testbench/par_regs_chk.sv
`timescale 1ns/1ps
module par_regs_chk
   import par_pkg::*;
(
   // clock and reset
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        clk_en,
   // apb
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [par_pkg::ADDR_W-1:0]  paddr,
   input wire logic [par_pkg::DATA_W-1:0]  pwdata,
   input wire logic [3:0]                  pstrb,
   input wire logic [par_pkg::DATA_W-1:0]  prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   // line side
   input wire logic                        word_confirmed,
   input wire logic                        remote_fault,
   input wire par_pkg::par_line_out_type   line_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_setup; psel && !penable && clk_en; endsequence
   sequence apb_done; psel && penable && pready; endsequence
   sequence rd_done(logic [11:0] a); apb_done ##0 (!pwrite && paddr == a); endsequence
   sequence ctrl_wr; apb_done ##0 (pwrite && paddr == 12'h040 && pstrb[0] && !pslverr);
   endsequence
   answer_time_a: assert property (apb_setup |=> pready) else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
   map_refuse_a: assert property (apb_done ##0 !(paddr inside {12'h008, 12'h00c, 12'h010,
      12'h014, 12'h040, 12'h080}) |-> pslverr && prdata == '0) else $error("bad address taken");
   hub_mode_a: assert property (line_out.crs_rx_only |->
      !line_out.full_duplex_allow && !line_out.heartbeat_on)
      else $error("hub mode leaks duplex");
   fiber_whiten_a: assert property (line_out.fiber_on |-> !line_out.whitening_on)
      else $error("whitening on in fiber mode");
   advert_fixed_a: assert property (rd_done(12'h010) |->
      prdata[15] == 1'b0 && prdata[9] == 1'b0 && prdata[4:0] == PROTO_FAMILY)
      else $error("advert fixed bits");
   partner_fixed_a: assert property (rd_done(12'h014) |->
      prdata[15] == 1'b0 && prdata[12:10] == 3'h0 && prdata[4:0] == PROTO_FAMILY)
      else $error("partner fixed bits");
   flags_track_a: assert property (rd_done(12'h010) or rd_done(12'h014) |->
      prdata[14] == $past(word_confirmed, 2) && prdata[13] == $past(remote_fault, 2))
      else $error("flag bits stale");
   id_zero_a: assert property (rd_done(12'h00c) |-> prdata[9:0] == 10'h000)
      else $error("part or issue code nonzero");
   ratio_jab_a: assert property (ctrl_wr |-> ##2
      (line_out.ratio_1p25 == $past(pwdata[6], 2) && line_out.jabber_on != $past(pwdata[2], 2)))
      else $error("control bits not applied");
endmodule : par_regs_chk
bind par_regs par_regs_chk par_regs_chk_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .word_confirmed(word_confirmed), .remote_fault(remote_fault), .line_out(line_out));

// >>> testbench/par_regs_tb.sv
`timescale 1ns/1ps
module par_regs_tb;
   import par_pkg::*;
   localparam logic [15:0] VID_LO = 16'h5a5a; // arbitrary value
   localparam logic [5:0]  VID_HI = 6'h15;    // arbitrary value
   localparam int          SETTLE0 = 4;
   localparam int          SETTLE3 = 7;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, ok;
   logic partner_load, word_confirmed, remote_fault;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [3:0]        pstrb;
   logic [15:0]       partner_word, rnd, v, adv;
   par_line_in_type   line_in;
   par_line_out_type  line_out;
   par_line_out_type  eo;
   logic [32:0]       exp_q[$];
   int                n_errors = 0;
   int                cmp_count = 0;
   int                n;
   always #5 pclk = ~pclk;
   par_regs #(.VENDOR_ID_LOW(VID_LO), .VENDOR_ID_HIGH(VID_HI), .SET0_CYCLES(SETTLE0),
      .SET1_CYCLES(5), .SET2_CYCLES(6), .SET3_CYCLES(SETTLE3)) par_regs_i (.pclk(pclk),
      .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .partner_word(partner_word), .partner_load(partner_load),
      .word_confirmed(word_confirmed), .remote_fault(remote_fault), .line_in(line_in),
      .line_out(line_out));
   par_mgmt_model par_mgmt_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic par_line_out_type exp_out(input logic [15:0] c, input logic [15:0] a,
                                                input par_line_in_type li);
      par_line_out_type o;
      o.full_duplex_allow = !c[15];
      o.heartbeat_on      = !c[15] && !c[11];
      o.crs_rx_only       = c[15];
      o.irq_pin           = c[14] ? li.irq_event : !li.irq_event;
      o.link_up           = c[4];
      o.arb_link_ready    = (!c[10] || li.burst_rx_idle) && (li.link_by_nlp ^ li.link_x_ready);
      o.descr_reload      = !li.descr_locked && (c[9] ? (li.st_quiet || li.st_halt ||
                            li.st_master || li.st_idle) : li.st_idle);
      o.power_save        = c[8] && !li.energy_seen;
      o.far_end_fault_on  = c[7];
      o.ratio_1p25        = c[6];
      o.auto_polarity_on  = !c[5];
      o.jabber_on         = !c[2];
      o.whitening_on      = c[1] && !c[0];
      o.fiber_on          = c[0];
      o.adv_abilities     = a[8:5];
      o.adv_pause         = a[12:10];
      return o;
   endfunction : exp_out
   task automatic check(input logic [63:0] seen, input logic [63:0] expd);
      cmp_count++;
      if (seen !== expd) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, expd);
      end
   endtask : check
   task automatic summarize;
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                      input logic [32:0] e);
      exp_q.push_back(e);
      par_mgmt_model_i.xfer(w, a, {16'h0, d}, ok);
      if (!ok) begin
         n_errors++;
         summarize();
      end
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0, {17'h0, e});
   endtask : rd
   // answers are matched in issue order against what was noted
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) check(64'h1, 64'h0);
         else check(64'({pslverr, prdata}), 64'(exp_q.pop_front()));
      end
   end
   initial begin
      pclk = 1'b0; presetn = 1'b0; clk_en = 1'b1; partner_word = '0; partner_load = 1'b0;
      word_confirmed = 1'b0; remote_fault = 1'b0; line_in = '0; rnd = 16'h0062;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(64'(line_out), 64'(exp_out(VCTRL_RST, 16'h01e1, line_in)));
      rd(12'h008, VID_LO);
      rd(12'h00c, {VID_HI, 10'h000});
      rd(12'h010, 16'h01e1);
      rd(12'h014, 16'h0001);
      rd(12'h040, VCTRL_RST);
      bus(1'b0, 12'h0c0, 16'h0, {1'b1, 32'h0});
      bus(1'b1, 12'h011, 16'hffff, {1'b1, 32'h0});
      bus(1'b1, 12'h008, 16'hffff, 33'h0);
      rd(12'h008, VID_LO);
      word_confirmed <= 1'b1;
      remote_fault <= 1'b1;
      bus(1'b1, 12'h010, 16'hffff, 33'h0);
      rd(12'h010, 16'h7de1);
      partner_word <= rnd;
      partner_load <= 1'b1;
      @(posedge pclk);
      partner_load <= 1'b0;
      rd(12'h014, {6'b011000, rnd[9:5], 5'h01});
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         v = rnd;
         rnd = lfsr(rnd);
         adv = rnd;
         line_in <= par_line_in_type'({1'b0, rnd[9:0]});
         bus(1'b1, 12'h040, v, 33'h0);
         bus(1'b1, 12'h010, adv, 33'h0);
         rd(12'h040, v & VCTRL_WMASK & ~{14'h0, v[0], 1'b0});
         rd(12'h010, {3'b011, adv[12:10], 1'b0, adv[8:5], 5'h01});
         // margin for the input synchronizer
         repeat (8) @(posedge pclk);
         eo = exp_out(v, adv, line_in);
         check(64'(line_out[20:13]), 64'(eo[20:13]));
         check(64'(line_out[12:0]), 64'(eo[12:0]));
         rd(12'h080, {11'h000, eo[17], eo[13], eo[14], eo[15], eo[16]});
      end
      // clock enable low: no load, no resync, outputs held
      clk_en <= 1'b0;
      partner_word <= ~partner_word;
      partner_load <= 1'b1;
      line_in.irq_event <= ~line_in.irq_event;
      repeat (6) @(posedge pclk);
      check(64'(line_out), 64'(eo));
      clk_en <= 1'b1;
      partner_load <= 1'b0;
      rd(12'h014, {6'b011000, ~partner_word[9:5], 5'h01});
      bus(1'b1, 12'h040, 16'h0003, 33'h0);
      rd(12'h040, 16'h0001);
      bus(1'b1, 12'h040, 16'h0000, 33'h0);
      bus(1'b1, 12'h040, 16'h3002, 33'h0);
      rd(12'h040, 16'h3002);
      // longest then shortest settle select, pulses good from the bus return edge
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, 12'h040, k ? 16'h0002 : 16'h3002, 33'h0);
         line_in.link_pulse_ok <= 1'b1;
         @(posedge pclk);
         check(64'(line_out.link_up), 64'h0);
         n = 0;
         while (line_out.link_up !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
         end
         // synchroniser edges, the settle count, then the output register
         check(64'(n), 64'(k ? SETTLE0 + 5 : SETTLE3 + 5));
         line_in.link_pulse_ok <= 1'b0;
         repeat (8) @(posedge pclk);
      end
      summarize();
   end
endmodule : par_regs_tb
